// >>> rtl/hrs_pkg.sv
// shared constants for the concealed-clock sram access block
// assumes one 20 MHz clock domain; pins are synchronised inside the top
package hrs_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 131072;
	localparam int SEQ_BITS = 64;
	localparam int SEQ_PTR_W = 6;
	localparam int REG_IDX_W = 3;
	localparam int REG_BIT_W = 3;
	localparam int PUSH_W = 11;
	// c5 3a a3 5c twice, bit 0 of the first byte sent first
	localparam logic [63:0] UNLOCK_PATTERN = 64'h5ca33ac55ca33ac5;
	localparam logic [5:0] SEQ_LAST = 6'h3f;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
	localparam logic [2:0] REG_HOURS = 3'h3;
	localparam logic [2:0] REG_DAY = 3'h4;
	localparam int DAY_RST_DIS_BIT = 4;
	localparam int DAY_OSC_STOP_BIT = 5;
	localparam int HOUR_MODE_BIT = 7;
	localparam int HOUR_PM_BIT = 5;
	localparam logic CTL_BITS_RESET = 1'b1;
	localparam logic HOUR_MODE_RESET = 1'b0;
	localparam logic [5:0] PTR_RESET = 6'h00;
	typedef enum logic [0:0] {
		ST_MATCH = 1'b0,
		ST_XFER = 1'b1
	} hrs_state_t;
endpackage

// >>> rtl/hrs_skid_buf.sv
// two-entry buffer, all outputs registered
// assumes source and sink share the clock of the instantiating block
`timescale 1ns/1ps
module hrs_skid_buf #(
	parameter int WIDTH = 11
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	logic [WIDTH-1:0] skid_r;
	logic skid_valid_r;
	logic take;
	logic give;

	assign take = in_valid_in && in_ready_out;
	assign give = out_valid_out && out_ready_in;

	// head entry: drives the sink directly
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			out_valid_out <= 1'b0;
			out_data_out <= '0;
		end else if (!out_valid_out || give) begin
			if (skid_valid_r) begin
				out_valid_out <= 1'b1;
				out_data_out <= skid_r;
			end else begin
				out_valid_out <= take;
				if (take) begin
					out_data_out <= in_data_in;
				end
			end
		end
	end

	// second entry catches a word while the sink stalls
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			skid_valid_r <= 1'b0;
			skid_r <= '0;
			in_ready_out <= 1'b1;
		end else begin
			if (skid_valid_r && (!out_valid_out || give)) begin
				skid_valid_r <= take;
				in_ready_out <= !take;
				if (take) begin
					skid_r <= in_data_in;
				end
			end else if (!skid_valid_r && take && out_valid_out && !give) begin
				skid_valid_r <= 1'b1;
				skid_r <= in_data_in;
				in_ready_out <= 1'b0;
			end
		end
	end
endmodule

// >>> rtl/hrs_access.sv
// sram access path with a concealed serial clock register window
// assumes pins arrive asynchronously; timekeeper shares ref_clk_in
//
// Behaviour
// - chip select low, write strobe high is a read; output enable low drives data
// - seventeen address bits pick one byte of the 128k array
// - write runs from later falling edge to earlier rising edge of select and strobe
// - host keeps output enable high in writes; falling strobe turns drivers off
// - power fail blocks every read and write to array and clock
// - unlock needs 64 consecutive writes matching the pattern on data bit 0
// - before unlock every cycle goes to the memory array
// - after unlock the next 64 cycles move clock data, array untouched
// - a read starts unlock and points the comparator at bit 0
// - any address accepted; unlock writes still store into memory
// - first unlock write compares with bit 0; a match advances the pointer
// - a mismatch freezes the pointer; later writes are ignored
// - any read during recognition aborts and rewinds the pointer
// - each transfer cycle moves one bit on data bit 0, direction by strobes
// - deselected cycles never disturb recognition or transfer
// - clock data is eight byte registers accessed one bit per cycle
// - timekeeping contents are binary-coded decimal
// - transfer runs bit 0 of register 0 through bit 7 of register 7
// - pattern is c5 3a a3 5c twice, least significant bit first
// - abort pin low ends transfer unless day bit 4 disables it
// - day bit 5 stops oscillator; both day control bits reset to one
// - hours bit 7 picks 12-hour mode; bit 5 then flags pm
`timescale 1ns/1ps
module hrs_access #(
	parameter int DEPTH = hrs_pkg::MEM_DEPTH
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic chip_sel_n_in,
	input wire logic out_en_n_in,
	input wire logic wr_strobe_n_in,
	input wire logic [hrs_pkg::ADDR_W-1:0] address_inputs_in,
	input wire logic [hrs_pkg::DATA_W-1:0] data_lines_in,
	output logic [hrs_pkg::DATA_W-1:0] data_lines_out,
	output logic data_lines_oe_n_out,
	input wire logic power_fail_threshold_in,
	input wire logic xfer_abort_n_in,
	input wire logic [hrs_pkg::SEQ_BITS-1:0] time_regs_in,
	output logic clk_wr_valid_out,
	output logic [hrs_pkg::PUSH_W-1:0] clk_wr_data_out,
	input wire logic clk_wr_ready_in,
	output logic clk_mode_out,
	output logic osc_stop_out,
	output logic reset_dis_out,
	output logic hour_12_out,
	output logic hour_pm_out,
	output logic push_lost_out
);
	import hrs_pkg::*;

	// synchroniser stages: stage one is read only by stage two
	logic [ADDR_W+DATA_W+4:0] sync1_r;
	logic [ADDR_W+DATA_W+4:0] sync2_r;
	logic ce_n_s, oe_n_s, we_n_s, pf_s, abort_n_s;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] din_s;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			sync1_r <= {1'b1, 1'b1, 1'b1, 1'b1, 1'b0, {(ADDR_W+DATA_W){1'b0}}};
			sync2_r <= {1'b1, 1'b1, 1'b1, 1'b1, 1'b0, {(ADDR_W+DATA_W){1'b0}}};
		end else begin
			sync1_r <= {chip_sel_n_in, out_en_n_in, wr_strobe_n_in, xfer_abort_n_in,
				power_fail_threshold_in, address_inputs_in, data_lines_in};
			sync2_r <= sync1_r;
		end
	end

	assign {ce_n_s, oe_n_s, we_n_s, abort_n_s, pf_s, addr_s, din_s} = sync2_r;

	// cycle decode, blocked while power is failing
	logic rd_act, wr_act, rd_prev_r, wr_prev_r, rd_end, wr_end;
	assign rd_act = !pf_s && !ce_n_s && we_n_s;
	assign wr_act = !pf_s && !ce_n_s && !we_n_s;
	// deselected cycles never reach the events below
	// a cycle cut short by power fail counts as nothing
	assign rd_end = rd_prev_r && !rd_act && !pf_s;
	assign wr_end = wr_prev_r && !wr_act && !pf_s;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			rd_prev_r <= 1'b0;
			wr_prev_r <= 1'b0;
		end else begin
			rd_prev_r <= rd_act;
			wr_prev_r <= wr_act;
		end
	end

	// address and data held from the last active write clock; host keeps address steady
	logic [ADDR_W-1:0] wr_addr_r;
	logic [DATA_W-1:0] wr_data_r;
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			wr_addr_r <= '0;
			wr_data_r <= '0;
		end else if (wr_act) begin
			wr_addr_r <= addr_s;
			wr_data_r <= din_s;
		end
	end

	// sequencer state
	hrs_state_t state_r;
	logic [SEQ_PTR_W-1:0] ptr_r;
	logic miss_r;
	logic [SEQ_PTR_W-1:0] xcnt_r;
	logic [SEQ_BITS-1:0] snap_r;
	logic [DATA_W-1:0] wbyte_r;
	logic abort_ok;
	logic pat_hit;
	logic mem_wr;
	logic unlock_hit;

	assign abort_ok = !abort_n_s && !reset_dis_out;
	assign pat_hit = wr_data_r[0] == UNLOCK_PATTERN[ptr_r];
	// unlock writes also land in memory
	assign mem_wr = wr_end && (state_r == ST_MATCH);
	// last pattern bit matched on this write end
	assign unlock_hit = state_r == ST_MATCH && wr_end && !miss_r && pat_hit && ptr_r == SEQ_LAST;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			state_r <= ST_MATCH;
			ptr_r <= PTR_RESET;
			miss_r <= 1'b0;
			xcnt_r <= PTR_RESET;
		end else begin
			case (state_r)
				ST_MATCH: begin
					if (rd_end) begin
						ptr_r <= PTR_RESET;
						miss_r <= 1'b0;
					end else if (wr_end && !miss_r) begin
						if (!pat_hit) begin
							miss_r <= 1'b1;
						end else if (ptr_r == SEQ_LAST) begin
							state_r <= ST_XFER;
							ptr_r <= PTR_RESET;
							xcnt_r <= PTR_RESET;
						end else begin
							ptr_r <= ptr_r + 6'h01;
						end
					end
				end
				ST_XFER: begin
					if (abort_ok) begin
						state_r <= ST_MATCH;
						miss_r <= 1'b0;
						ptr_r <= PTR_RESET;
					end else if (rd_end || wr_end) begin
						xcnt_r <= xcnt_r + 6'h01;
						if (xcnt_r == SEQ_LAST) begin
							state_r <= ST_MATCH;
							ptr_r <= PTR_RESET;
							miss_r <= 1'b0;
						end
					end
				end
				default: begin
					state_r <= ST_MATCH;
				end
			endcase
		end
	end

	// coherent time image, so a rollover cannot split a read
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			snap_r <= '0;
		end else if (unlock_hit) begin
			snap_r <= time_regs_in;
		end
	end

	// serial byte assembly; one bit per write cycle on bit 0
	logic byte_done;
	logic [DATA_W-1:0] byte_full;
	assign byte_full = {wr_data_r[0], wbyte_r[DATA_W-1:1]};
	assign byte_done = state_r == ST_XFER && !abort_ok && wr_end && xcnt_r[REG_BIT_W-1:0] == BYTE_LAST_BIT;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			wbyte_r <= '0;
		end else if (state_r == ST_XFER && (wr_end || rd_end)) begin
			// a read bit shifts in a zero; partial groups are the host's problem
			wbyte_r <= {wr_end ? wr_data_r[0] : 1'b0, wbyte_r[DATA_W-1:1]};
		end
	end

	// completed bytes go to the timekeeper as {register, bcd byte}
	logic pend_r;
	logic [PUSH_W-1:0] pend_data_r;
	logic buf_ready;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			pend_r <= 1'b0;
			pend_data_r <= '0;
			push_lost_out <= 1'b0;
		end else begin
			if (byte_done) begin
				pend_r <= 1'b1;
				pend_data_r <= {xcnt_r[SEQ_PTR_W-1:REG_BIT_W], byte_full};
				// word still waiting means the timekeeper stalled a whole byte time
				if (pend_r && !buf_ready) begin
					push_lost_out <= 1'b1;
				end
			end else if (pend_r && buf_ready) begin
				pend_r <= 1'b0;
			end
		end
	end

	hrs_skid_buf #(
		.WIDTH(PUSH_W)
	) u_wr_buf (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.in_valid_in(pend_r),
		.in_data_in(pend_data_r),
		.in_ready_out(buf_ready),
		.out_valid_out(clk_wr_valid_out),
		.out_data_out(clk_wr_data_out),
		.out_ready_in(clk_wr_ready_in)
	);

	// control bits kept locally; only reset_dis_out steers this block, through the abort pin
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			osc_stop_out <= CTL_BITS_RESET;
			reset_dis_out <= CTL_BITS_RESET;
			hour_12_out <= HOUR_MODE_RESET;
			hour_pm_out <= 1'b0;
		end else if (byte_done) begin
			if (xcnt_r[SEQ_PTR_W-1:REG_BIT_W] == REG_DAY) begin
				osc_stop_out <= byte_full[DAY_OSC_STOP_BIT];
				reset_dis_out <= byte_full[DAY_RST_DIS_BIT];
			end else if (xcnt_r[SEQ_PTR_W-1:REG_BIT_W] == REG_HOURS) begin
				hour_12_out <= byte_full[HOUR_MODE_BIT];
				hour_pm_out <= byte_full[HOUR_MODE_BIT] && byte_full[HOUR_PM_BIT];
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			clk_mode_out <= 1'b0;
		end else begin
			clk_mode_out <= state_r == ST_XFER;
		end
	end

	// array storage; no reset, contents are nonvolatile in spirit
	logic [DATA_W-1:0] mem_r [DEPTH];
	always_ff @(posedge ref_clk_in) begin
		if (mem_wr) begin
			mem_r[wr_addr_r] <= wr_data_r;
		end
	end

	// read drivers; synchronised strobe low removes the drive on the next clock
	logic drive;
	assign drive = rd_act && !oe_n_s;
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			data_lines_oe_n_out <= 1'b1;
			data_lines_out <= '0;
		end else begin
			data_lines_oe_n_out <= !drive;
			if (drive) begin
				if (state_r == ST_XFER) begin
					data_lines_out <= {7'h00, snap_r[xcnt_r]};
				end else begin
					data_lines_out <= mem_r[addr_s];
				end
			end
		end
	end

	// checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	pf_block_a: assert property (pf_s |-> !mem_wr && !rd_act && !wr_act)
		else $error("access seen during power fail");
	drv_off_a: assert property (!we_n_s |=> data_lines_oe_n_out)
		else $error("data driven while write strobe low");
	rd_drive_a: assert property (drive |=> !data_lines_oe_n_out)
		else $error("read not driving data");
	xfer_nomem_a: assert property (state_r == ST_XFER |-> !mem_wr)
		else $error("array written during transfer");
	unlock_enter_a: assert property (unlock_hit
		|=> state_r == ST_XFER && xcnt_r == 6'h00 && clk_mode_out == 1'b0 ##1 clk_mode_out)
		else $error("full pattern did not unlock");
	read_rewind_a: assert property (state_r == ST_MATCH && rd_end |=> ptr_r == 6'h00 && !miss_r)
		else $error("read did not rewind pointer");
	miss_hold_a: assert property (state_r == ST_MATCH && miss_r && !rd_end
		|=> $stable(ptr_r) && state_r == ST_MATCH)
		else $error("pointer moved after mismatch");
	match_step_a: assert property (state_r == ST_MATCH && wr_end && !miss_r && pat_hit
		&& ptr_r != SEQ_LAST |=> ptr_r == $past(ptr_r) + 6'h01)
		else $error("pointer did not advance on match");
	xfer_leave_a: assert property (state_r == ST_XFER && !abort_ok && (rd_end || wr_end)
		&& xcnt_r == SEQ_LAST |=> state_r == ST_MATCH && ptr_r == 6'h00)
		else $error("transfer did not end after 64 cycles");
	abort_pin_a: assert property (state_r == ST_XFER && abort_ok |=> state_r == ST_MATCH)
		else $error("abort pin ignored");
	// the end of a cycle still falls in its first deselected clock, so only quiet clocks count
	idle_keep_a: assert property ((ce_n_s && !rd_prev_r && !wr_prev_r && !abort_ok) [*2]
		|-> ($stable(ptr_r) && $stable(xcnt_r) && $stable(state_r)) [*2])
		else $error("deselected cycle disturbed sequence");

	unlock_c: cover property (state_r == ST_MATCH ##1 state_r == ST_XFER);
	byte_c: cover property (byte_done && xcnt_r[SEQ_PTR_W-1:REG_BIT_W] == REG_DAY);
	stall_c: cover property (clk_wr_valid_out && !clk_wr_ready_in ##1 pend_r && !buf_ready);
	miss_c: cover property (state_r == ST_MATCH && $rose(miss_r));
endmodule

// >>> bench/hrs_tk_model.sv
// timekeeper stand-in: takes pushed clock bytes, shows them as live time registers
// assumes the clock and reset of the access block
`timescale 1ns/1ps
module hrs_tk_model (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic stall_in,
	input wire logic push_valid_in,
	input wire logic [hrs_pkg::PUSH_W-1:0] push_data_in,
	output logic push_ready_out,
	output logic [hrs_pkg::SEQ_BITS-1:0] time_regs_out
);
	import hrs_pkg::*;
	// ready held off on demand so the bench can fill the buffer
	assign push_ready_out = !stall_in;
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			time_regs_out <= 64'h0;
		end else if (push_valid_in && push_ready_out) begin
			time_regs_out[push_data_in[10:8]*8 +: 8] <= push_data_in[7:0];
		end
	end
endmodule

// >>> bench/hrs_access_test.sv
// self-checking bench for the concealed-clock sram access block
// assumes the timekeeper model; abort pin pulled low only around transfers
`timescale 1ns/1ps
module hrs_access_test;
	import hrs_pkg::*;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic ce_n = 1'b1;
	logic oe_n = 1'b1;
	logic we_n = 1'b1;
	logic pf = 1'b0;
	logic stall = 1'b0;
	logic abort_n = 1'b1;
	logic [16:0] addr = 17'h0;
	logic [7:0] host_d = 8'hff;
	logic [7:0] dq, dout, rd_q;
	logic oe_n_out, rd_oe, pvalid, pready;
	logic [10:0] pdata;
	logic [63:0] tregs;
	logic cmode, osc, rdis, h12, hpm, lost;
	// bcd bytes; hours a5 = 12-hour pm, day 00 = both control bits cleared
	localparam logic [63:0] WB = 64'h1706_1500_a512_1130;
	int n_errors = 0;
	int check_count = 0;
	// wire level: device when it drives, else host value
	assign dq = !oe_n_out ? dout : host_d;
	initial forever #25 ref_clk_in = !ref_clk_in;
	hrs_access dut_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .chip_sel_n_in(ce_n),
		.out_en_n_in(oe_n), .wr_strobe_n_in(we_n), .address_inputs_in(addr), .data_lines_in(dq),
		.data_lines_out(dout), .data_lines_oe_n_out(oe_n_out), .power_fail_threshold_in(pf),
		.xfer_abort_n_in(abort_n), .time_regs_in(tregs), .clk_wr_valid_out(pvalid),
		.clk_wr_data_out(pdata), .clk_wr_ready_in(pready), .clk_mode_out(cmode), .osc_stop_out(osc),
		.reset_dis_out(rdis), .hour_12_out(h12), .hour_pm_out(hpm), .push_lost_out(lost));
	hrs_tk_model tk_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .stall_in(stall),
		.push_valid_in(pvalid), .push_data_in(pdata), .push_ready_out(pready), .time_regs_out(tregs));
	task automatic stop_test();
		if (n_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	// one whole cycle: 5 clocks active, 5 idle; sel low leaves chip select high
	task automatic bus(input logic sel, input logic wr, input logic [16:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		ce_n <= !sel;
		we_n <= !wr;
		oe_n <= wr; // enable stays off in writes
		addr <= a; // held through the whole cycle
		host_d <= d;
		repeat (4) @(posedge ref_clk_in);
		#1;
		rd_q = dout;
		rd_oe = oe_n_out;
		@(posedge ref_clk_in);
		ce_n <= 1'b1;
		we_n <= 1'b1;
		oe_n <= 1'b1;
		host_d <= ~d;
		repeat (4) @(posedge ref_clk_in);
	endtask
	task automatic settle();
		repeat (3) @(posedge ref_clk_in);
		#1;
	endtask
	// priming read, then 64 pattern writes to one scratch byte, one deselected cycle inside
	task automatic unlock(input int bad);
		bus(1'b1, 1'b0, 17'h9, 8'h0);
		for (int i = 0; i < 64; i++) begin
			if (i == 20) bus(1'b0, 1'b1, 17'h9, 8'hff);
			bus(1'b1, 1'b1, 17'h9, {7'h0, UNLOCK_PATTERN[i] ^ (i == bad)});
		end
		settle();
	endtask
	task automatic t_mem();
		bus(1'b1, 1'b1, 17'h00005, 8'ha5);
		bus(1'b1, 1'b1, 17'h10005, 8'h5a);
		bus(1'b1, 1'b0, 17'h00005, 8'h0);
		chk(rd_oe === 1'b0 && rd_q === 8'ha5, "memory read back");
	endtask
	task automatic t_pf();
		pf <= 1'b1;
		bus(1'b1, 1'b1, 17'h5, 8'h3c);
		bus(1'b1, 1'b0, 17'h5, 8'h0);
		chk(rd_oe === 1'b1, "drive during power fail");
		pf <= 1'b0;
		bus(1'b1, 1'b0, 17'h5, 8'h0);
		// drive checked too: a silent read would leave the old a5 on the lines
		chk(rd_oe === 1'b0 && rd_q === 8'ha5, "write during power fail stored");
	endtask
	task automatic t_miss();
		bus(1'b1, 1'b1, 17'h3, 8'h77);
		unlock(3);
		chk(cmode === 1'b0, "unlock with a wrong bit");
		bus(1'b1, 1'b0, 17'h9, 8'h0);
		chk(rd_q === {7'h0, UNLOCK_PATTERN[63]}, "unlock write not stored");
	endtask
	// abort pin low early on, while the day register still tells the block to ignore it
	task automatic t_xfer_wr();
		unlock(99);
		chk(cmode === 1'b1, "no clock mode after pattern");
		@(posedge ref_clk_in);
		stall <= 1'b1;
		abort_n <= 1'b0;
		for (int k = 0; k < 64; k++) begin
			if (k == 24) begin
				stall <= 1'b0;
				abort_n <= 1'b1;
			end
			bus(1'b1, 1'b1, k[16:0], {7'h0, WB[k]});
		end
		settle();
		chk(cmode === 1'b0, "clock mode not left");
		chk(tregs === WB && lost === 1'b0, "pushed clock bytes");
		chk(osc === 1'b0 && rdis === 1'b0, "day control bits");
		chk(h12 === 1'b1 && hpm === 1'b1, "hours mode bits");
		bus(1'b1, 1'b0, 17'h3, 8'h0);
		chk(rd_q === 8'h77, "memory touched in transfer");
	endtask
	// day bit 4 now clear: the pin cuts a transfer short and no byte is pushed
	task automatic t_abort();
		unlock(99);
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, 1'b1, k[16:0], 8'h0);
		end
		abort_n <= 1'b0;
		settle();
		settle();
		chk(cmode === 1'b0 && tregs === WB, "abort pin in transfer");
		@(posedge ref_clk_in);
		abort_n <= 1'b1;
	endtask
	task automatic t_xfer_rd();
		unlock(99);
		for (int k = 0; k < 64; k++) begin
			bus(1'b1, 1'b0, k[16:0], 8'h0);
			chk(rd_q === {7'h0, WB[k]}, "clock read bit");
		end
		settle();
		chk(cmode === 1'b0, "clock mode not left after reads");
	endtask
	initial begin
		repeat (2) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		chk(osc === 1'b1 && rdis === 1'b1 && h12 === 1'b0 && hpm === 1'b0, "control bit reset");
		t_mem();
		t_pf();
		t_miss();
		t_xfer_wr();
		t_abort();
		t_xfer_rd();
		stop_test();
	end
	initial begin
		repeat (60000) @(posedge ref_clk_in);
		n_errors++;
		stop_test();
	end
endmodule
